// *** src/rbs_defines.svh ***
// Purpose: Constants for the reset and boot sequencer
// Assumes: 32-bit AXI4-Lite register bus, byte addresses
// Notes:   Offsets are byte addresses of aligned words
`ifndef RBS_DEFINES_SVH
`define RBS_DEFINES_SVH
// Register offsets
`define RBS_OFF_HOST_CTL      8'h00
`define RBS_OFF_STATUS        8'h04
`define RBS_OFF_CONFIG        8'h08
`define RBS_OFF_VECTOR        8'h0c
`define RBS_OFF_EVENT         8'h10
// host_control_high fields
`define RBS_HC_HALT           0
`define RBS_HC_NMI            1
`define RBS_HC_NOSAVE         2
// Config fields, loaded from vector bits [3:0]
`define RBS_CFG_BYTE_ORDER    0
`define RBS_CFG_RCA0          1
`define RBS_CFG_RCA1          2
`define RBS_CFG_PROTECT       3
// Reset vector address
`define RBS_RESET_VECTOR      32'hffffffe0
// Sequencing counts and bus response codes
`define RBS_INIT_REFRESHES    4'h8
`define RBS_INTERNAL_RESET    6'h22
`define RBS_REFRESH_PERIOD    4'h8
`define RBS_RESP_OKAY         2'b00
`define RBS_RESP_SLVERR       2'b10
`endif

// *** src/rbs_pkg.sv ***
// Purpose: Types for the reset and boot sequencer
// Assumes: Nothing beyond the defines header
// Notes:   Gray codes along the host-present boot path; self-boot INIT to FETCH flips two bits
package rbs_pkg;
   typedef enum logic [2:0] {
      RBS_ST_INTRST = 3'b000,
      RBS_ST_INIT   = 3'b001,
      RBS_ST_HALT   = 3'b011,
      RBS_ST_FETCH  = 3'b010,
      RBS_ST_RUN    = 3'b110
   } rbs_state_t;
   typedef enum logic [1:0] {
      RBS_ENT_NONE  = 2'b00,
      RBS_ENT_RESET = 2'b01,
      RBS_ENT_NMI   = 2'b10,
      RBS_ENT_TRAP0 = 2'b11
   } rbs_entry_t;
endpackage : rbs_pkg

// *** src/rbs_refresh_timer.sv ***
// Purpose: Periodic refresh request generator
// Assumes: Enable held while refresh is allowed
// Notes:   Pulse once every PERIOD cycles while enabled
`include "rbs_defines.svh"
module rbs_refresh_timer #(
   parameter logic [3:0] PERIOD = `RBS_REFRESH_PERIOD
) (
   // Clock and reset
   input  wire logic clk_sys,
   input  wire logic resetn,
   // Control
   input  wire logic enable,
   output      logic tick
);
   logic [3:0] count;
   wire        wrap = (count == PERIOD - 4'h1);

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         count <= 4'h0;
         tick  <= 1'b0;
      end else begin
         count <= (!enable || wrap) ? 4'h0 : count + 4'h1;
         tick  <= enable && wrap;
      end
   end
endmodule : rbs_refresh_timer

// *** src/rbs_sequencer.sv ***
// Purpose: Reset, refresh initialisation and boot sequencing
// Assumes: resetn and host_chip_select synchronous to clk_sys
// Notes:   Software view over AXI4-Lite; memory sits outside
//
// Contract
// R1 - Held reset keeps outputs defined, no refresh of DRAM or display.
// R2 - Chip select sampled in the cycle before reset rises picks start mode.
// R3 - Host-present start halts until host writes the halt bit to zero.
// R4 - Host-present mode runs eight row-strobe initialisation cycles; host waits.
// R5 - While halted, periodic DRAM refresh continues.
// R6 - Host-present mode fetches reset vector only after halt bit clears.
// R7 - Self-boot mode refreshes eight times, then fetches vector at ffffffe0.
// R8 - Vector low four bits load byte order and row/column configuration.
// R9 - Reset entry saves neither flags word nor program counter.
// R10 - Host NMI with nosave mode set skips saving flags and counter.
// R11 - Trap-0 uses the reset vector and saves nothing.
// R12 - Power-up reset is held low at least 40 local clocks.
// R13 - Other resets are held low at least four local clocks.
// R14 - After reset the device stays in internal reset for 34 cycles.
// R15 - Refresh continues during internal reset once reset input is high.
// R16 - Host NMI request is taken regardless of interrupt masking.
// R17 - Reset clears all I/O registers except the halt bit.
// R18 - Halt bit set to sampled chip select at reset release.
// R19 - Init refreshes are column-before-row; no memory grant before they end.
//
// Added by the designer: the placing of the registers and the AXI4-Lite interface to the registers.
`include "rbs_defines.svh"
module rbs_sequencer #(
   parameter logic [5:0]  INTRST_CYCLES = `RBS_INTERNAL_RESET,
   parameter logic [3:0]  INIT_COUNT    = `RBS_INIT_REFRESHES,
   parameter logic [31:0] VECTOR_ADDR   = `RBS_RESET_VECTOR
) (
   // Clock and reset
   input  wire logic        clk_sys,
   input  wire logic        resetn,
   // Host strap
   input  wire logic        host_chip_select,
   // Core events
   input  wire logic        trap0_request,
   // Memory side
   output      logic        refresh_req,
   output      logic        refresh_cbr,
   output      logic        display_refresh_en,
   output      logic        mem_grant,
   output      logic        vector_fetch_req,
   output      logic [31:0] vector_fetch_addr,
   input  wire logic        vector_fetch_ack,
   input  wire logic [31:0] vector_fetch_data,
   // Core side
   output      logic        core_run,
   output      logic        entry_pulse,
   output      logic [1:0]  entry_kind,
   output      logic        entry_save_state,
   // AXI4-Lite slave
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output      logic        s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output      logic        s_axi_wready,
   output      logic [1:0]  s_axi_bresp,
   output      logic        s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output      logic        s_axi_arready,
   output      logic [31:0] s_axi_rdata,
   output      logic [1:0]  s_axi_rresp,
   output      logic        s_axi_rvalid,
   input  wire logic        s_axi_rready
);
   function automatic logic is_mapped(input logic [7:0] a);
      is_mapped = (a == `RBS_OFF_HOST_CTL) || (a == `RBS_OFF_STATUS) ||
                  (a == `RBS_OFF_CONFIG) || (a == `RBS_OFF_VECTOR) ||
                  (a == `RBS_OFF_EVENT);
   endfunction : is_mapped

   rbs_pkg::rbs_state_t state;
   rbs_pkg::rbs_state_t next_state;
   logic [5:0]  intrst_count;
   logic [3:0]  init_count;
   logic        halt_hold_bit;
   logic        host_nmi_req;
   logic        interrupt_nosave_mode;
   logic [3:0]  config_bits;
   logic [31:0] program_counter;
   logic        nmi_seen;
   logic        trap_seen;
   logic        strap_taken;
   logic [7:0]  aw_addr;
   logic        aw_held;
   logic [31:0] w_data;
   logic [3:0]  w_strb;
   logic        w_held;
   logic        tick;

   // R2 strap capture
   // Reset is asynchronous; the first clock edge with reset high sees the prior-cycle level
   logic        strap_level;
   wire         first_high = !strap_taken;

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         strap_taken <= 1'b0;
         strap_level <= 1'b0;
      end else begin
         strap_taken <= 1'b1;
         if (first_high)
            strap_level <= host_chip_select;
      end
   end

   // R15 refresh during internal reset
   // R5 refresh while halted
   wire refresh_allowed = (state != rbs_pkg::RBS_ST_INIT);

   // Refresh keeps running in halt, so memory survives a long host wait
   rbs_refresh_timer #(
      .PERIOD (`RBS_REFRESH_PERIOD)
   ) u_timer (
      .clk_sys (clk_sys),
      .resetn  (resetn),
      .enable  (refresh_allowed),
      .tick    (tick)
   );

   wire intrst_done = (intrst_count == INTRST_CYCLES - 6'h1);
   wire init_done   = (init_count == INIT_COUNT - 4'h1);

   // Write and read channel decode
   wire aw_ok      = s_axi_awvalid && s_axi_awready;
   wire w_ok       = s_axi_wvalid && s_axi_wready;
   wire have_aw    = aw_held || aw_ok;
   wire have_w     = w_held || w_ok;
   wire [7:0] wa   = aw_held ? aw_addr : s_axi_awaddr;
   wire [31:0] wd  = w_held ? w_data : s_axi_wdata;
   wire [3:0] ws   = w_held ? w_strb : s_axi_wstrb;
   wire do_write   = have_aw && have_w && !s_axi_bvalid;
   wire wr_hc      = do_write && (wa == `RBS_OFF_HOST_CTL) && ws[0];
   wire wr_ev      = do_write && (wa == `RBS_OFF_EVENT) && ws[0];
   wire wr_mapped  = is_mapped(wa);
   wire ar_ok      = s_axi_arvalid && s_axi_arready;
   wire rd_mapped  = is_mapped(s_axi_araddr);

   // R19 column-before-row init cycles, one every cycle pair
   logic init_phase;
   wire  tick_init = (state == rbs_pkg::RBS_ST_INIT) && init_phase;

   // R16 unmasked host NMI
   // Taken only in RUN; a request made while halted waits for the routine
   wire nmi_take   = host_nmi_req && (state == rbs_pkg::RBS_ST_RUN) && !entry_pulse;
   wire trap_take  = trap0_request && (state == rbs_pkg::RBS_ST_RUN) && !nmi_take
                     && !entry_pulse;

   always_comb begin
      next_state = state;
      case (state)
         // R14 internal reset length
         rbs_pkg::RBS_ST_INTRST: if (intrst_done) next_state = rbs_pkg::RBS_ST_INIT;
         // R4 eight init cycles
         // R7 self-boot goes straight to fetch
         rbs_pkg::RBS_ST_INIT: if (init_done && tick_init)
            next_state = halt_hold_bit ? rbs_pkg::RBS_ST_HALT : rbs_pkg::RBS_ST_FETCH;
         // R3 stay halted
         // R6 fetch after halt clears
         rbs_pkg::RBS_ST_HALT: if (!halt_hold_bit) next_state = rbs_pkg::RBS_ST_FETCH;
         rbs_pkg::RBS_ST_FETCH: if (vector_fetch_ack) next_state = rbs_pkg::RBS_ST_RUN;
         rbs_pkg::RBS_ST_RUN: if (trap_take) next_state = rbs_pkg::RBS_ST_FETCH;
         default: next_state = rbs_pkg::RBS_ST_INTRST;
      endcase
   end

   // Output decode, named so the register block below stays short
   wire fetch_done   = (state == rbs_pkg::RBS_ST_FETCH) && vector_fetch_ack;
   wire next_run     = (next_state == rbs_pkg::RBS_ST_RUN);
   wire next_fetch   = (next_state == rbs_pkg::RBS_ST_FETCH);
   wire next_granted = (next_state == rbs_pkg::RBS_ST_HALT) || next_fetch || next_run;
   wire boot_entry   = (state != rbs_pkg::RBS_ST_RUN) && (state != rbs_pkg::RBS_ST_FETCH);
   wire refresh_now  = tick || tick_init;
   // Event clears, a set in the same cycle still wins
   wire clr_nmi      = wr_ev && wd[0];
   wire clr_trap     = wr_ev && wd[1];

   // R1 defined outputs under reset
   // R17 registers cleared
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         state        <= rbs_pkg::RBS_ST_INTRST;
         intrst_count <= 6'h00;
         init_count   <= 4'h0;
         init_phase   <= 1'b0;
      end else begin
         state        <= next_state;
         intrst_count <= (state == rbs_pkg::RBS_ST_INTRST) ? intrst_count + 6'h01 : 6'h00;
         init_phase   <= (state == rbs_pkg::RBS_ST_INIT) ? !init_phase : 1'b0;
         if (tick_init)
            init_count <= init_count + 4'h1;
      end
   end

   // R18 halt bit from strap
   // R3 host clears halt
   // Strap load beats a host write in the first cycle after release
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         halt_hold_bit         <= 1'b0;
         host_nmi_req          <= 1'b0;
         interrupt_nosave_mode <= 1'b0;
      end else begin
         if (first_high)
            halt_hold_bit <= host_chip_select;
         else if (wr_hc)
            halt_hold_bit <= wd[`RBS_HC_HALT];
         if (nmi_take)
            host_nmi_req <= 1'b0;
         else if (wr_hc)
            host_nmi_req <= wd[`RBS_HC_NMI];
         if (wr_hc)
            interrupt_nosave_mode <= wd[`RBS_HC_NOSAVE];
      end
   end

   // R8 configuration from vector
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         config_bits     <= 4'h0;
         program_counter <= 32'h00000000;
      end else if (fetch_done) begin
         if (entry_kind == rbs_pkg::RBS_ENT_RESET)
            config_bits <= vector_fetch_data[3:0];
         program_counter <= {vector_fetch_data[31:4], 4'h0};
      end
   end

   // Sticky events, set wins over clear
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         nmi_seen  <= 1'b0;
         trap_seen <= 1'b0;
      end else begin
         nmi_seen  <= nmi_take || (nmi_seen && !clr_nmi);
         trap_seen <= trap_take || (trap_seen && !clr_trap);
      end
   end

   // Outputs, all registered
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         refresh_req        <= 1'b0;
         refresh_cbr        <= 1'b0;
         display_refresh_en <= 1'b0;
         mem_grant          <= 1'b0;
         vector_fetch_req   <= 1'b0;
         vector_fetch_addr  <= 32'h00000000;
         core_run           <= 1'b0;
         entry_pulse        <= 1'b0;
         entry_kind         <= rbs_pkg::RBS_ENT_NONE;
         entry_save_state   <= 1'b0;
      end else begin
         // R19 CBR refresh, grant only after init
         refresh_req        <= refresh_now;
         refresh_cbr        <= refresh_now;
         display_refresh_en <= next_run;
         mem_grant          <= next_granted;
         vector_fetch_req   <= next_fetch && !fetch_done;
         // R7 vector address
         // R11 trap-0 shares reset vector
         vector_fetch_addr  <= VECTOR_ADDR;
         core_run           <= next_run;
         entry_pulse        <= fetch_done || nmi_take;
         // R9 reset saves nothing
         if (boot_entry)
            entry_kind <= rbs_pkg::RBS_ENT_RESET;
         else if (nmi_take)
            entry_kind <= rbs_pkg::RBS_ENT_NMI;
         else if (trap_take)
            entry_kind <= rbs_pkg::RBS_ENT_TRAP0;
         // R10 nosave NMI
         // R11 trap-0 saves nothing
         entry_save_state   <= nmi_take && !interrupt_nosave_mode;
      end
   end

   // Bus slave, unmapped address answers SLVERR
   wire [31:0] rd_word =
      (s_axi_araddr == `RBS_OFF_HOST_CTL) ? {29'h0, interrupt_nosave_mode, host_nmi_req,
                                             halt_hold_bit} :
      (s_axi_araddr == `RBS_OFF_STATUS)   ? {26'h0, strap_level, mem_grant, core_run,
                                             state} :
      (s_axi_araddr == `RBS_OFF_CONFIG)   ? {28'h0, config_bits} :
      (s_axi_araddr == `RBS_OFF_VECTOR)   ? program_counter :
      (s_axi_araddr == `RBS_OFF_EVENT)    ? {30'h0, trap_seen, nmi_seen} : 32'h0;

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         aw_held       <= 1'b0;
         aw_addr       <= 8'h00;
         w_held        <= 1'b0;
         w_data        <= 32'h00000000;
         w_strb        <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= `RBS_RESP_OKAY;
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h00000000;
         s_axi_rresp   <= `RBS_RESP_OKAY;
      end else begin
         if (aw_ok) begin
            aw_held <= !do_write;
            aw_addr <= s_axi_awaddr;
         end else if (do_write) begin
            aw_held <= 1'b0;
         end
         if (w_ok) begin
            w_held <= !do_write;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end else if (do_write) begin
            w_held <= 1'b0;
         end
         s_axi_awready <= !have_aw && !s_axi_bvalid;
         s_axi_wready  <= !have_w && !s_axi_bvalid;
         if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_mapped ? `RBS_RESP_OKAY : `RBS_RESP_SLVERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
         s_axi_arready <= !s_axi_rvalid && !ar_ok;
         if (ar_ok) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_word;
            s_axi_rresp  <= rd_mapped ? `RBS_RESP_OKAY : `RBS_RESP_SLVERR;
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end
endmodule : rbs_sequencer

// *** testbench/rbs_seq_monitor.sv ***
// Purpose: Port checks for the reset and boot sequencer
// Assumes: One clock, resetn asynchronous active low
// Notes:   Refresh bounds allow two cycles of timer slack
module rbs_seq_monitor #(
   parameter logic [5:0] INTRST_CYCLES = 6'h22
) (
   // Clock and reset
   input wire logic        clk_sys,
   input wire logic        resetn,
   // Memory side
   input wire logic        refresh_req,
   input wire logic        refresh_cbr,
   input wire logic        mem_grant,
   input wire logic        vector_fetch_req,
   input wire logic [31:0] vector_fetch_addr,
   input wire logic        vector_fetch_ack,
   // Core side
   input wire logic        core_run,
   input wire logic        entry_pulse,
   input wire logic [1:0]  entry_kind,
   input wire logic        entry_save_state
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [11:0] cyc;
   logic [7:0]  nref;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!resetn);
   // Saturating, so long runs never wrap into false alarms
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         cyc  <= 12'h000;
         nref <= 8'h00;
      end else begin
         if (cyc != 12'hfff) cyc <= cyc + 12'h001;
         if (refresh_req && nref != 8'hff) nref <= nref + 8'h01;
      end
   end
   property p_quiet; $rose(resetn) |-> !(refresh_req | mem_grant | core_run); endproperty
   a_quiet: assert property (p_quiet) else $error("active at release");
   property p_cbr; refresh_req |-> refresh_cbr; endproperty
   a_cbr: assert property (p_cbr) else $error("refresh not cbr");
   property p_intrst; mem_grant |-> cyc >= 12'(INTRST_CYCLES) + 12'h00e; endproperty
   a_intrst: assert property (p_intrst) else $error("grant too early");
   property p_init; $rose(mem_grant) |-> nref >= 8'h08; endproperty
   a_init: assert property (p_init) else $error("grant before refreshes");
   property p_alive; cyc != 12'h000 |-> ##[0:10] refresh_req; endproperty
   a_alive: assert property (p_alive) else $error("refresh stalled");
   property p_fetch;
      vector_fetch_req |-> mem_grant && vector_fetch_addr == 32'hffffffe0;
   endproperty
   a_fetch: assert property (p_fetch) else $error("bad fetch");
   property p_entry;
      $rose(core_run) |-> entry_pulse && !entry_save_state && $past(vector_fetch_ack);
   endproperty
   a_entry: assert property (p_entry) else $error("bad entry");
   property p_save; entry_save_state |-> entry_pulse && entry_kind == 2'h2; endproperty
   a_save: assert property (p_save) else $error("bad save");
   c_run: cover property ($rose(core_run));
   c_save: cover property (entry_save_state);
   c_trap: cover property (entry_pulse && entry_kind == 2'h3);
endmodule : rbs_seq_monitor
bind rbs_sequencer rbs_seq_monitor #(.INTRST_CYCLES(INTRST_CYCLES)) u_mon (
   .clk_sys, .resetn, .refresh_req, .refresh_cbr, .mem_grant, .vector_fetch_req,
   .vector_fetch_addr, .vector_fetch_ack, .core_run, .entry_pulse, .entry_kind,
   .entry_save_state
);

// *** testbench/rbs_mem_model.sv ***
// Purpose: Local memory answering vector fetches
// Assumes: Request held until the cycle after ack
// Notes:   Idle data toggles so a stale word never looks valid
module rbs_mem_model (
   // Clock and reset
   input  wire logic        clk_sys,
   input  wire logic        resetn,
   // Controls
   input  wire logic [31:0] vec_word,
   input  wire logic [3:0]  delay,
   // Fetch port
   input  wire logic        vector_fetch_req,
   output      logic        vector_fetch_ack,
   output      logic [31:0] vector_fetch_data
);
   timeunit 1ns;
   timeprecision 1ps;
   logic       pend;
   logic [3:0] wait_cnt;
   assign pend = vector_fetch_req && !vector_fetch_ack;
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         vector_fetch_ack  <= 1'b0;
         vector_fetch_data <= 32'h0;
         wait_cnt          <= 4'h0;
      end else if (pend && wait_cnt == delay) begin
         vector_fetch_ack  <= 1'b1;
         vector_fetch_data <= vec_word;
         wait_cnt          <= 4'h0;
      end else begin
         vector_fetch_ack  <= 1'b0;
         vector_fetch_data <= ~vector_fetch_data;
         wait_cnt          <= pend ? wait_cnt + 4'h1 : 4'h0;
      end
   end
endmodule : rbs_mem_model

// *** testbench/testbench.sv ***
// Purpose: Self-checking bench for the reset and boot sequencer
// Assumes: Full 34-cycle internal reset; write strobes set unless a test clears them
// Notes:   Waits are bounded; a lapse counts as a mismatch
`include "rbs_defines.svh"
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [31:0] VEC_A = 32'h00400105;
   localparam logic [31:0] VEC_B = 32'h0080020a;
   logic        clk_sys = 1'b0, resetn = 1'b0, host_chip_select = 1'b0, trap0_request = 1'b0;
   logic        refresh_req, refresh_cbr, display_refresh_en, mem_grant, vector_fetch_req;
   logic        vector_fetch_ack, core_run, entry_pulse, entry_save_state, ent_s;
   logic [1:0]  entry_kind, s_axi_bresp, s_axi_rresp, ent_k;
   logic [31:0] vector_fetch_addr, vector_fetch_data, s_axi_rdata, rd;
   logic [31:0] vec_word = VEC_A, s_axi_wdata = 32'h0;
   logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [3:0]  mem_delay = 4'h0, s_axi_wstrb = 4'hf;
   logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   int          n_fail = 0, checks = 0, n_ent = 0, e_mark = 0;
   always #4 clk_sys = ~clk_sys;
   always @(posedge clk_sys) begin
      if (entry_pulse === 1'b1) begin
         ent_k <= entry_kind;
         ent_s <= entry_save_state;
         n_ent <= n_ent + 1;
      end
   end
   rbs_sequencer dut (
      .clk_sys, .resetn, .host_chip_select, .trap0_request, .refresh_req, .refresh_cbr,
      .display_refresh_en, .mem_grant, .vector_fetch_req, .vector_fetch_addr,
      .vector_fetch_ack, .vector_fetch_data, .core_run, .entry_pulse, .entry_kind,
      .entry_save_state, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
   );
   rbs_mem_model mem (
      .clk_sys, .resetn, .vec_word, .delay(mem_delay), .vector_fetch_req,
      .vector_fetch_ack, .vector_fetch_data
   );
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic final_report();
      $display("checks %0d mismatches %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : final_report
   task automatic bound(input int n);
      if (n >= 400) begin
         n_fail++;
         $display("mismatch at %0t: wait ran out, seen %h expected %h", $time, n, 0);
         final_report();
      end
   endtask : bound
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      int n;
      n = 0;
      @(posedge clk_sys);
      s_axi_awaddr  <= a;
      s_axi_wdata   <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      do begin
         @(posedge clk_sys);
         n++;
         if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
         if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1 && n < 400);
      s_axi_bready <= 1'b0;
      bound(n);
      check({30'h0, s_axi_bresp}, {30'h0, er});
   endtask : axi_wr
   task automatic axi_rd(input logic [7:0] a, input logic [1:0] er);
      int n;
      n = 0;
      @(posedge clk_sys);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      do begin
         @(posedge clk_sys);
         n++;
         if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1 && n < 400);
      s_axi_rready <= 1'b0;
      rd = s_axi_rdata;
      bound(n);
      check({30'h0, s_axi_rresp}, {30'h0, er});
   endtask : axi_rd
   task automatic do_reset(input logic strap, input int len);
      @(posedge clk_sys);
      resetn           <= 1'b0;
      host_chip_select <= strap;
      repeat (len) @(posedge clk_sys);
      check({27'h0, refresh_req, mem_grant, core_run, display_refresh_en, entry_pulse}, 0);
      resetn <= 1'b1;
   endtask : do_reset
   // Kind 0 waits for the memory grant, otherwise for a new entry
   task automatic wait_on(input int sel);
      int n;
      for (n = 0; n < 400; n++) begin
         @(posedge clk_sys);
         if (sel == 0 ? mem_grant === 1'b1 : n_ent != e_mark) break;
      end
      bound(n);
   endtask : wait_on
   task automatic check_entry(input logic [1:0] k, input logic s);
      check({29'h0, ent_k, ent_s}, {29'h0, k, s});
   endtask : check_entry
   initial begin
      repeat (8) @(posedge clk_sys);
      do_reset(1'b0, 32);
      wait_on(1);
      check_entry(rbs_pkg::RBS_ENT_RESET, 1'b0);
      axi_rd(`RBS_OFF_CONFIG, `RBS_RESP_OKAY);
      check(rd, {28'h0, VEC_A[3:0]});
      axi_rd(`RBS_OFF_VECTOR, `RBS_RESP_OKAY);
      check(rd, {VEC_A[31:4], 4'h0});
      axi_rd(`RBS_OFF_HOST_CTL, `RBS_RESP_OKAY);
      check(rd, 32'h0);
      axi_rd(`RBS_OFF_STATUS, `RBS_RESP_OKAY);
      check(rd, {26'h0, 3'b011, rbs_pkg::RBS_ST_RUN});
      check({29'h0, display_refresh_en, mem_grant, core_run}, 32'h7);
      $display("test self boot done");
      for (int m = 0; m < 2; m++) begin
         e_mark = n_ent;
         axi_wr(`RBS_OFF_HOST_CTL, {29'h0, m[0], 2'b10}, `RBS_RESP_OKAY);
         wait_on(1);
         check_entry(rbs_pkg::RBS_ENT_NMI, ~m[0]);
      end
      $display("test nmi done");
      vec_word <= VEC_B;
      e_mark = n_ent;
      trap0_request <= 1'b1;
      @(posedge clk_sys);
      trap0_request <= 1'b0;
      wait_on(1);
      check_entry(rbs_pkg::RBS_ENT_TRAP0, 1'b0);
      axi_rd(`RBS_OFF_VECTOR, `RBS_RESP_OKAY);
      check(rd, {VEC_B[31:4], 4'h0});
      axi_rd(`RBS_OFF_CONFIG, `RBS_RESP_OKAY);
      check(rd, {28'h0, VEC_A[3:0]});
      axi_rd(`RBS_OFF_EVENT, `RBS_RESP_OKAY);
      check(rd, 32'h3);
      axi_wr(`RBS_OFF_EVENT, 32'h3, `RBS_RESP_OKAY);
      axi_rd(`RBS_OFF_EVENT, `RBS_RESP_OKAY);
      check(rd, 32'h0);
      axi_rd(8'h20, `RBS_RESP_SLVERR);
      check(rd, 32'h0);
      axi_wr(8'h20, 32'hffffffff, `RBS_RESP_SLVERR);
      $display("test trap done");
      mem_delay <= 4'h5;
      vec_word  <= VEC_A;
      do_reset(1'b1, 4);
      wait_on(0);
      repeat (40) @(posedge clk_sys);
      check({30'h0, display_refresh_en, core_run | vector_fetch_req}, 32'h0);
      s_axi_wstrb <= 4'he;
      axi_wr(`RBS_OFF_HOST_CTL, 32'h0, `RBS_RESP_OKAY);
      s_axi_wstrb <= 4'hf;
      axi_rd(`RBS_OFF_HOST_CTL, `RBS_RESP_OKAY);
      check(rd, 32'h1);
      axi_rd(`RBS_OFF_STATUS, `RBS_RESP_OKAY);
      check(rd, {26'h0, 3'b110, rbs_pkg::RBS_ST_HALT});
      axi_rd(`RBS_OFF_EVENT, `RBS_RESP_OKAY);
      check(rd, 32'h0);
      e_mark = n_ent;
      axi_wr(`RBS_OFF_HOST_CTL, 32'h0, `RBS_RESP_OKAY);
      wait_on(1);
      check_entry(rbs_pkg::RBS_ENT_RESET, 1'b0);
      $display("test host present done");
      final_report();
   end
endmodule : testbench
